/* File: logic/ebwh_top.sv */
// ebwh_top: external bus interface, mode select, slow-memory wait and bus hold
// assumes core requests held stable until o_cpu_done; pins synchronous to i_sys_clk
// Functional notes
// - processor mode field, bits 1:0 of mode register A, picks the operating mode
// - expanded modes turn the four low ports into bus pins
// - port direction addresses become external accesses when expanded
// - first port drives address low byte, second port the high byte
// - third port is the bidirectional data bus for data and opcodes
// - fourth port carries ready, outputs, dma, clock, sync, write and read strobes
// - reset with boot mode pin low gives single-chip mode
// - writing 01 with boot pin low gives memory expansion, internal rom kept
// - boot pin high at reset or writing 10 gives microprocessor mode, rom off
// - waits only for external expanded accesses, never for 0x0008 to 0x000F
// - mode register B bits 3:0 hold wait length and wait mode fields
// - software wait stretches strobe low by 0 to 3 phi, ready ignored
// - ready wait: low ready at cycle start adds the selected phi cycles
// - extended ready: sample ready each phi, end wait within selection after high
// - hold requests honoured only while hold enable bit is one
// - low hold request puts device in hold for as long as it stays low
// - clock keeps running during hold so peripherals continue
// - hold acknowledge driven low when the bus is released
// - during hold address and data float, strobes high, clock output toggles
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module ebwh_top (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_boot_mode_pin,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire ebwh_pkg::ebwh_req_type i_cpu_req,
    input wire logic i_cpu_internal,
    input wire logic i_cpu_sync,
    input wire logic i_cpu_dma,
    input wire logic i_cpu_expanded_data_strobe,
    output logic o_cpu_done,
    output logic [7:0] o_cpu_rdata,
    output logic o_ext_map,
    output logic o_rom_valid,
    output logic o_expanded,
    output logic [7:0] o_low_address_port,
    output logic [7:0] o_low_address_port_oe,
    output logic [7:0] o_high_address_port,
    output logic [7:0] o_high_address_port_oe,
    input wire logic [7:0] i_data_bus_port,
    output logic [7:0] o_data_bus_port,
    output logic [7:0] o_data_bus_port_oe,
    input wire logic i_ready_wait_n,
    output logic o_dma_cycle_strobe,
    output logic o_clk_out,
    output logic o_opcode_fetch_sync,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic o_expanded_data_strobe,
    input wire logic i_hold_req_n,
    output logic o_bus_grant_ack_n
);
    import ebwh_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    logic [7:0] mode_a_q, mode_b_q;
    logic strap_done_q;
    logic [1:0] pm;
    logic [1:0] wlen, wmode;
    logic hold_en, expanded;
    assign pm = mode_a_q[EBWH_PM_LSB +: 2];
    assign wlen = mode_b_q[EBWH_WLEN_LSB +: 2];
    assign wmode = mode_b_q[EBWH_WMODE_LSB +: 2];
    assign hold_en = mode_b_q[EBWH_HOLD_EN_BIT];
    assign expanded = (pm == EBWH_PM_EXPAND) || (pm == EBWH_PM_MICRO);

    // strap caught on the first clock after release, not under reset
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_a_q <= EBWH_MODE_A_RST;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            if (i_boot_mode_pin) begin
                mode_a_q[EBWH_PM_LSB +: 2] <= EBWH_PM_MICRO;
            end else begin
                mode_a_q[EBWH_PM_LSB +: 2] <= EBWH_PM_SINGLE;
            end
        end else if (i_reg_wr && i_reg_addr == EBWH_ADDR_MODE_A) begin
            mode_a_q <= i_reg_wdata;
        end
    end

    // mode B: wait length, wait mode, hold enable
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_b_q <= EBWH_MODE_B_RST;
        end else if (i_reg_wr && i_reg_addr == EBWH_ADDR_MODE_B) begin
            mode_b_q <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd && i_reg_addr == EBWH_ADDR_MODE_A) begin
            o_reg_rdata <= mode_a_q;
        end else if (i_reg_rd && i_reg_addr == EBWH_ADDR_MODE_B) begin
            o_reg_rdata <= mode_b_q;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic is_port_dir(input logic [15:0] a);
        is_port_dir = (a >= EBWH_SFR_LO) && (a <= EBWH_SFR_HI) && a[0];
    endfunction
    function automatic logic in_sfr(input logic [15:0] a);
        in_sfr = (a >= EBWH_SFR_LO) && (a <= EBWH_SFR_HI);
    endfunction

    logic ext_access;
    // direction registers of the bus ports go out to the bus
    assign o_ext_map = expanded && is_port_dir(i_cpu_req.addr);
    assign ext_access = expanded && (!i_cpu_internal || o_ext_map);
    assign o_rom_valid = (pm != EBWH_PM_MICRO);
    assign o_expanded = expanded;

    // ------------------------------------------------------------
    // hold handling
    // ------------------------------------------------------------
    ebwh_state_type state_q;
    logic hold_q;
    logic [1:0] wcnt_q;
    logic rdy_seen_q;
    // hold is only granted between cycles, so a transfer never splits
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hold_q <= 1'b0;
        end else if (hold_q) begin
            hold_q <= !i_hold_req_n;
        end else if (hold_en && !i_hold_req_n && state_q == EBWH_IDLE) begin
            hold_q <= 1'b1;
        end
    end
    assign o_bus_grant_ack_n = !hold_q;

    // ------------------------------------------------------------
    // external cycle and wait sequencing
    // ------------------------------------------------------------
    // a request meeting a hold request waits while hold is enabled; the outside master goes first
    logic start;
    assign start = (i_cpu_req.rd || i_cpu_req.wr) && ext_access && !hold_q
        && (hold_en ? i_hold_req_n : 1'b1) && state_q == EBWH_IDLE;

    logic stretch;
    assign stretch = !in_sfr(i_cpu_req.addr);

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= EBWH_IDLE;
            wcnt_q <= EBWH_WLEN_ZERO;
            rdy_seen_q <= 1'b0;
        end else begin
            case (state_q)
                EBWH_IDLE: begin
                    if (start) begin
                        state_q <= EBWH_STROBE;
                        rdy_seen_q <= 1'b0;
                        if (!stretch) begin
                            wcnt_q <= EBWH_WLEN_ZERO;
                        end else if (wmode == EBWH_WM_SOFT) begin
                            wcnt_q <= wlen;
                        end else if (!i_ready_wait_n) begin
                            wcnt_q <= wlen;
                            rdy_seen_q <= (wmode == EBWH_WM_XRDY);
                        end else begin
                            wcnt_q <= EBWH_WLEN_ZERO;
                        end
                    end
                end
                EBWH_STROBE: begin
                    // extended ready holds the count until ready is seen high
                    if (rdy_seen_q && !i_ready_wait_n) begin
                        wcnt_q <= wlen;
                    end else if (wcnt_q != EBWH_WLEN_ZERO) begin
                        rdy_seen_q <= 1'b0;
                        wcnt_q <= wcnt_q - 2'd1;
                    end else begin
                        rdy_seen_q <= 1'b0;
                        state_q <= EBWH_DONE;
                    end
                end
                EBWH_DONE: begin
                    state_q <= EBWH_IDLE;
                end
                default: begin
                    state_q <= EBWH_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic drive;
    assign drive = expanded && !hold_q;
    // strobe low exactly while the sequencer stays in the strobe state,
    // so it never spills into the done cycle
    logic strobe_hold;
    assign strobe_hold = (state_q == EBWH_STROBE)
        && ((rdy_seen_q && !i_ready_wait_n) || wcnt_q != EBWH_WLEN_ZERO);
    logic [15:0] addr_q;
    logic [7:0] wdata_q, rdata_q;
    logic wr_n_q, rd_n_q, wr_cyc_q;
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            wr_cyc_q <= 1'b0;
        end else if (start) begin
            addr_q <= i_cpu_req.addr;
            wdata_q <= i_cpu_req.wdata;
            wr_cyc_q <= i_cpu_req.wr;
        end
    end
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else begin
            wr_n_q <= !(start && i_cpu_req.wr) && !(strobe_hold && wr_cyc_q);
            rd_n_q <= !(start && i_cpu_req.rd) && !(strobe_hold && !wr_cyc_q);
        end
    end
    // read data captured as the strobe rises
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (state_q == EBWH_STROBE && !rd_n_q) begin
            rdata_q <= i_data_bus_port;
        end
    end
    // phi rendered as a divided clock out; never gated by hold
    logic clk_div_q, sync_q, dma_q, expanded_data_strobe_q;
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clk_div_q <= 1'b0;
            sync_q <= 1'b0;
            dma_q <= 1'b0;
            expanded_data_strobe_q <= 1'b1;
        end else begin
            clk_div_q <= !clk_div_q;
            sync_q <= start && i_cpu_sync;
            dma_q <= start && i_cpu_dma;
            expanded_data_strobe_q <= !(start && i_cpu_expanded_data_strobe);
        end
    end

    // ------------------------------------------------------------
    // limitations
    // ------------------------------------------------------------
    // wait mode 01 is served like ready wait, no behaviour of its own
    // extended ready with zero length ends on the edge ready is seen high
    // hold is granted between cycles only, so a stretched cycle delays it

    // done pulses once the strobe is high again; the core may then drop its request
    assign o_cpu_done = (state_q == EBWH_DONE);
    assign o_cpu_rdata = rdata_q;
    assign o_low_address_port = addr_q[7:0];
    assign o_high_address_port = addr_q[15:8];
    assign o_low_address_port_oe = {8{drive}};
    assign o_high_address_port_oe = {8{drive}};
    assign o_data_bus_port = wdata_q;
    assign o_data_bus_port_oe = {8{drive && wr_cyc_q && state_q != EBWH_IDLE}};
    assign o_wr_n = wr_n_q || !drive;
    assign o_rd_n = rd_n_q || !drive;
    assign o_clk_out = clk_div_q && expanded;
    assign o_opcode_fetch_sync = sync_q;
    assign o_dma_cycle_strobe = dma_q;
    assign o_expanded_data_strobe = expanded_data_strobe_q;
endmodule

/* File: logic/ebwh_pkg.sv */
// ebwh_pkg: constants and carrier types for the external bus wait/hold block
// assumes one 40 MHz clock; phi is one system clock cycle here
package ebwh_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] EBWH_ADDR_MODE_A = 16'h0000;
    localparam logic [15:0] EBWH_ADDR_MODE_B = 16'h0001;
    localparam logic [15:0] EBWH_SFR_LO = 16'h0008;
    localparam logic [15:0] EBWH_SFR_HI = 16'h000F;
    localparam logic [7:0] EBWH_MODE_A_RST = 8'h00;
    localparam logic [7:0] EBWH_MODE_B_RST = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EBWH_PM_LSB = 0;
    localparam int EBWH_WLEN_LSB = 0;
    localparam int EBWH_WMODE_LSB = 2;
    localparam int EBWH_HOLD_EN_BIT = 4;
    localparam logic [1:0] EBWH_PM_SINGLE = 2'b00;
    localparam logic [1:0] EBWH_PM_EXPAND = 2'b01;
    localparam logic [1:0] EBWH_PM_MICRO = 2'b10;
    localparam logic [1:0] EBWH_WM_SOFT = 2'b00;
    localparam logic [1:0] EBWH_WM_RDY = 2'b10;
    localparam logic [1:0] EBWH_WM_XRDY = 2'b11;
    localparam logic [1:0] EBWH_WLEN_ZERO = 2'b00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ebwh_req_type;
    typedef struct packed {
        logic [7:0] rd_n_wr_n_ctl;
    } ebwh_dummy_type;
    typedef enum logic [1:0] {EBWH_IDLE, EBWH_STROBE, EBWH_DONE} ebwh_state_type;
endpackage

/* File: bench/ebwh_ext_mem.sv */
// ebwh_ext_mem: external memory with a ready pin that can hold a cycle off
// assumes address and strobes come straight from the block's bus pins
`timescale 1ns/100ps
module ebwh_ext_mem (
    input wire logic i_clk,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [3:0] i_slow,
    output logic [7:0] o_data,
    output logic o_ready_n
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [3:0] cnt = 4'h0;
    always @(posedge i_clk) begin
        if (!i_wr_n) mem[i_addr[7:0]] <= i_data;
        if (!i_rd_n) last <= mem[i_addr[7:0]];
        cnt <= (i_rd_n && i_wr_n) ? 4'h0 : cnt + 4'h1;
    end
    // released bus shows the inverse so a stale byte never passes
    assign o_data = !i_rd_n ? mem[i_addr[7:0]] : ~last;
    // low from cycle start until slow strobe cycles have passed
    assign o_ready_n = cnt >= i_slow;
endmodule

/* File: bench/ebwh_top_asserts.sv */
// ebwh_top_asserts: pin timing checks for the bus and hold logic
// assumes it sees only the top module's ports
`timescale 1ns/100ps
module ebwh_top_asserts (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_hold_req_n,
    input wire ebwh_pkg::ebwh_req_type i_cpu_req,
    input wire logic i_cpu_sync,
    input wire logic i_cpu_dma,
    input wire logic i_cpu_expanded_data_strobe,
    input wire logic o_ext_map,
    input wire logic o_expanded,
    input wire logic [7:0] o_low_address_port,
    input wire logic [7:0] o_low_address_port_oe,
    input wire logic [7:0] o_high_address_port,
    input wire logic [7:0] o_high_address_port_oe,
    input wire logic [7:0] o_data_bus_port_oe,
    input wire logic o_clk_out,
    input wire logic o_opcode_fetch_sync,
    input wire logic o_dma_cycle_strobe,
    input wire logic o_expanded_data_strobe,
    input wire logic o_wr_n,
    input wire logic o_rd_n,
    input wire logic o_bus_grant_ack_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_hold_strobes_high: assert property (!o_bus_grant_ack_n |-> o_rd_n && o_wr_n)
        else $error("strobe low while bus granted");
    a_hold_float_bus: assert property (!o_bus_grant_ack_n |->
        (o_low_address_port_oe | o_high_address_port_oe | o_data_bus_port_oe) == 8'h00)
        else $error("bus driven while granted");
    a_grant_after_req: assert property ($fell(o_bus_grant_ack_n) |-> !$past(i_hold_req_n))
        else $error("grant without request");
    a_release_ack: assert property (!o_bus_grant_ack_n && i_hold_req_n |=> o_bus_grant_ack_n)
        else $error("grant kept after release");
    a_clk_out_runs: assert property (o_expanded && $past(o_expanded) |->
        o_clk_out != $past(o_clk_out))
        else $error("clock output stalled");
    a_single_chip_quiet: assert property (!o_expanded |->
        o_rd_n && o_wr_n && o_low_address_port_oe == 8'h00)
        else $error("bus active in single chip mode");
    a_strobe_exclusive: assert property (o_rd_n || o_wr_n)
        else $error("both strobes low");
    a_addr_match: assert property (!o_rd_n || !o_wr_n |->
        {o_high_address_port, o_low_address_port} == i_cpu_req.addr)
        else $error("address pins wrong");
    a_sfr_no_stretch: assert property (($fell(o_rd_n) || $fell(o_wr_n)) &&
        i_cpu_req.addr[15:3] == 13'h0001 |=> o_rd_n && o_wr_n)
        else $error("stretched access to 0x0008-0x000F");
    a_dir_ext_map: assert property (i_cpu_req.addr == 16'h0009 |-> o_ext_map == o_expanded)
        else $error("direction register not mapped out");
    a_qual_follow: assert property (($fell(o_rd_n) || $fell(o_wr_n)) |->
        o_opcode_fetch_sync == $past(i_cpu_sync) && o_dma_cycle_strobe == $past(i_cpu_dma)
        && o_expanded_data_strobe == !$past(i_cpu_expanded_data_strobe))
        else $error("cycle qualifiers wrong");
endmodule
bind ebwh_top ebwh_top_asserts u_chk (.i_sys_clk, .i_nrst, .i_hold_req_n, .i_cpu_req,
    .i_cpu_sync, .i_cpu_dma, .i_cpu_expanded_data_strobe, .o_ext_map, .o_expanded, .o_low_address_port,
    .o_low_address_port_oe, .o_high_address_port, .o_high_address_port_oe,
    .o_data_bus_port_oe, .o_clk_out, .o_opcode_fetch_sync, .o_dma_cycle_strobe,
    .o_expanded_data_strobe, .o_wr_n, .o_rd_n, .o_bus_grant_ack_n);

/* File: bench/external_bus_wait_hold_ctrl_bench.sv */
// external_bus_wait_hold_ctrl_bench: mode, wait and hold scenarios
// assumes the external memory model and the bound checker
`timescale 1ns/100ps
module external_bus_wait_hold_ctrl_bench;
    import ebwh_pkg::*;
    logic i_sys_clk, i_nrst, i_reg_wr, i_reg_rd, i_cpu_internal, i_ready_wait_n, i_hold_req_n;
    logic [15:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, o_cpu_rdata, i_data_bus_port, o_data_bus_port;
    logic [7:0] o_data_bus_port_oe, o_low_address_port, o_high_address_port, mem_q, e, d;
    ebwh_req_type i_cpu_req;
    logic o_cpu_done, o_rom_valid, o_expanded, o_wr_n, o_rd_n, o_bus_grant_ack_n;
    logic rd_d, done_d, i_boot_mode_pin;
    logic [2:0] qual;
    logic [7:0] w_exp;
    logic [3:0] slow;
    logic [7:0] expq [$];
    int n_mismatch, check_count, wcnt, cyc, m;
    ebwh_top uut (.i_sys_clk, .i_nrst, .i_boot_mode_pin, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_cpu_req, .i_cpu_internal, .i_cpu_sync(qual[0]),
        .i_cpu_dma(qual[1]), .i_cpu_expanded_data_strobe(qual[2]), .o_cpu_done, .o_cpu_rdata, .o_ext_map(),
        .o_rom_valid, .o_expanded, .o_low_address_port, .o_low_address_port_oe(),
        .o_high_address_port, .o_high_address_port_oe(), .i_data_bus_port, .o_data_bus_port,
        .o_data_bus_port_oe, .i_ready_wait_n, .o_dma_cycle_strobe(), .o_clk_out(),
        .o_opcode_fetch_sync(), .o_wr_n, .o_rd_n, .o_expanded_data_strobe(), .i_hold_req_n,
        .o_bus_grant_ack_n);
    ebwh_ext_mem u_mem (.i_clk(i_sys_clk), .i_addr({o_high_address_port, o_low_address_port}),
        .i_data(i_data_bus_port), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_slow(slow),
        .o_data(mem_q), .o_ready_n(i_ready_wait_n));
    assign i_data_bus_port = (o_data_bus_port_oe != 8'h00) ? o_data_bus_port : mem_q;
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic reg_acc(input logic w, input logic [15:0] a, input logic [7:0] v);
        if (!w) expq.push_back(v);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= v;
        i_reg_wr <= w;
        i_reg_rd <= !w;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
    endtask
    // width 0 in the queue means the strobe length is not checked
    task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] v,
                       input logic [7:0] wid);
        int k;
        expq.push_back(wid);
        @(posedge i_sys_clk);
        i_cpu_req <= '{addr: a, wdata: v, wr: w, rd: !w};
        i_cpu_internal <= (a < 16'h0010);
        qual <= 3'($urandom);
        k = 0;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (o_cpu_done !== 1'b1 && k < 60);
        @(posedge i_sys_clk);
        i_cpu_req <= '0;
        qual <= 3'h0;
        if (k >= 60) chk("cpu_done", 8'h01, 8'h00);
        if (!w) expq.push_back(v);
    endtask
    always @(posedge i_sys_clk) begin
        if (rd_d) chk("reg_rdata", expq.pop_front(), o_reg_rdata);
        if (done_d) chk("cpu_rdata", expq.pop_front(), o_cpu_rdata);
        if (!(o_rd_n && o_wr_n)) wcnt++;
        else if (wcnt > 0) begin
            w_exp = expq.pop_front();
            if (w_exp != 8'h00) chk("strobe_width", w_exp, wcnt[7:0]);
            wcnt = 0;
        end
        rd_d = i_reg_rd;
        done_d = o_cpu_done && i_cpu_req.rd;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        {i_nrst, i_reg_wr, i_reg_rd, i_cpu_internal, i_reg_addr, i_reg_wdata} = '0;
        i_cpu_req = '0;
        i_hold_req_n = 1'b1;
        i_boot_mode_pin = 1'b0;
        qual = 3'h0;
        slow = 4'h0;
        void'($urandom(32));
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        chk("expanded", 8'h00, {7'h0, o_expanded});
        reg_acc(1'b0, EBWH_ADDR_MODE_A, EBWH_MODE_A_RST);
        reg_acc(1'b0, EBWH_ADDR_MODE_B, EBWH_MODE_B_RST);
        reg_acc(1'b0, 16'h1234, 8'h00);
        reg_acc(1'b1, EBWH_ADDR_MODE_A, 8'h01);
        @(negedge i_sys_clk);
        chk("mode_pins", 8'h03, {6'h0, o_expanded, o_rom_valid});
        reg_acc(1'b1, EBWH_ADDR_MODE_A, 8'h02);
        @(negedge i_sys_clk);
        chk("mode_pins", 8'h02, {6'h0, o_expanded, o_rom_valid});
        for (m = 0; m < 16; m++) begin
            reg_acc(1'b1, EBWH_ADDR_MODE_B, {4'h0, m[3:0]});
            slow = 4'($urandom_range(0, 4));
            e = (m[3:2] == 2'b00 || slow != 4'h0) ? 8'(1 + m[1:0]) : 8'h01;
            if (m[3:2] == 2'b11 && slow != 4'h0) e = 8'h00;
            d = 8'($urandom);
            cpu(1'b1, 16'h8000 | 16'($urandom), d, e);
            cpu(1'b0, {o_high_address_port, o_low_address_port}, d, e);
        end
        slow = 4'h0;
        reg_acc(1'b1, EBWH_ADDR_MODE_B, 8'h03);
        cpu(1'b1, 16'h0009, 8'h5A, 8'h01);
        cpu(1'b0, 16'h0009, 8'h5A, 8'h01);
        @(posedge i_sys_clk);
        i_hold_req_n <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk("grant_ack", 8'h01, {7'h0, o_bus_grant_ack_n});
        @(posedge i_sys_clk);
        i_hold_req_n <= 1'b1;
        reg_acc(1'b1, EBWH_ADDR_MODE_B, 8'h10);
        @(posedge i_sys_clk);
        i_hold_req_n <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk("grant_ack", 8'h00, {7'h0, o_bus_grant_ack_n});
        fork
            begin
                repeat (8) @(posedge i_sys_clk);
                i_hold_req_n <= 1'b1;
            end
            cpu(1'b1, 16'hC0DE, 8'hA5, 8'h01);
        join
        chk("grant_ack", 8'h01, {7'h0, o_bus_grant_ack_n});
        repeat (4) @(posedge i_sys_clk);
        i_boot_mode_pin <= 1'b1;
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        chk("strap_pins", 8'h02, {6'h0, o_expanded, o_rom_valid});
        repeat (2) @(posedge i_sys_clk);
        tally_and_finish();
    end
endmodule
